// [verilog/rxp_page_bank.sv]
/*
 * Receive port register paging bank: per-source page control, routing of
 * paged reads and broadcast writes, and per-port embedded type units.
 * Assumes all requests and packet strobes come from logic on mclk; the
 * per-port status blocks live outside and present their bytes on
 * pg_rdata_all for the address on pg_raddr.
 */
// Notes on behaviour
// - Embedding types first lines with the 6-bit code, reset 0x12.
// - Count 00 keeps raw; 01-11 embed 1-3 packets; none in packet mode.
// - Only the per-port address ranges and the embedded type byte go through the page settings.
// - Two-bit read port field picks which port block answers paged reads.
// - Read port defaults to 0 locally, to its own port over a channel.
// - Read-only origin field reads 0 locally, carrying port over a channel.
// - Four write enables, bit is port; writes reach every enabled block.
// - Enable 0 blocks writes, 1 allows them, for every paged register.
// - Enables reset to 0 locally; channel sources enable their own port.
// - Each source keeps its own page settings, unseen by the others.
// - First port status register shows the selected read port in 7:6.
`timescale 1ns/1ps
`include "rxp_page_cfg.svh"
module rxp_page_bank
  import rxp_page_pkg::*;
#(
  parameter int NUM_LOCAL = `RXP_NUM_LOCAL
)
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 req_valid,
  input  wire logic [`RXP_SRC_W-1:0] req_src,
  input  wire logic                 req_write,
  input  rxp_byte_type              req_addr,
  input  rxp_byte_type              req_wdata,
  output logic                      rsp_valid,
  output rxp_byte_type              rsp_rdata,
  output rxp_byte_type              pg_raddr,
  input  wire logic [31:0]          pg_rdata_all,
  output logic [3:0]                pg_wr_mask,
  output rxp_byte_type              pg_waddr,
  output rxp_byte_type              pg_wdata,
  input  wire logic [3:0]           frame_start,
  input  wire logic [3:0]           pkt_start,
  input  wire logic [3:0]           csi_mode,
  input  wire logic [23:0]          raw_dtype,
  output logic [23:0]               pkt_dtype
);

  ////////////////////////////////////////////////////////////////////////////

  // Sources below NUM_LOCAL are the local serial ports; the rest are the
  // control channels of receive ports 0 to 3 in order.
  function automatic logic src_is_chan(input logic [`RXP_SRC_W-1:0] s);
    return (32'(s) >= NUM_LOCAL);
  endfunction

  function automatic rxp_port_type src_port(input logic [`RXP_SRC_W-1:0] s);
    if (src_is_chan(s)) begin
      return rxp_port_type'(32'(s) - NUM_LOCAL);
    end
    return 2'h0;
  endfunction

  function automatic logic is_paged(input rxp_byte_type a);
    return ((a >= `RXP_PAGED_LO_A) && (a <= `RXP_PAGED_HI_A))
        || ((a >= `RXP_PAGED_LO_B) && (a <= `RXP_PAGED_HI_B));
  endfunction

  // Reset page of one source: a channel master starts out reading and
  // writing only the port whose link carries it.
  function automatic rxp_page_type page_reset(input int idx);
    rxp_page_type pg;
    pg.rd_port = 2'h0;
    pg.wen     = 4'h0;
    if (idx >= NUM_LOCAL) begin
      pg.rd_port = rxp_port_type'(idx - NUM_LOCAL);
      pg.wen     = 4'(1 << (idx - NUM_LOCAL));
    end
    return pg;
  endfunction

  // Page select readback: origin port, read port, then write enables.
  // The origin field comes from the source code and cannot be written.
  function automatic rxp_byte_type sel_byte(
    input logic [`RXP_SRC_W-1:0] s,
    input rxp_page_type          pg
  );
    rxp_byte_type b;
    b[`RXP_PHYS_MSB:`RXP_PHYS_LSB]     = src_port(s);
    b[`RXP_RDPORT_MSB:`RXP_RDPORT_LSB] = pg.rd_port;
    b[`RXP_WEN_MSB:`RXP_WEN_LSB]       = pg.wen;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  rxp_page_type page_r [`RXP_NUM_SRC];
  rxp_page_type cur;
  rxp_byte_type rd_nxt;
  rxp_byte_type embed_ctl [`RXP_NUM_PORTS];
  logic [3:0]   embed_wr;
  logic         wr_req;
  logic         rd_req;
  logic         src_ok;
  logic         hit_sel;
  logic         hit_embed;
  logic         hit_paged;
  logic         hit_sts1;

  assign wr_req    = req_valid && req_write;
  assign rd_req    = req_valid && !req_write;
  // Codes past the last channel have no copy; they see a local page with
  // every enable clear, so a stray code can never write a port block.
  assign src_ok    = 32'(req_src) < `RXP_NUM_SRC;
  assign cur       = src_ok ? page_r[req_src] : '0;
  assign pg_raddr  = req_addr;
  // Address decode shared by the read mux, the page copies and the writes.
  assign hit_sel   = req_addr == `RXP_ADDR_PAGE_SEL;
  assign hit_embed = req_addr == `RXP_ADDR_EMBED_CTL;
  assign hit_paged = is_paged(req_addr);
  assign hit_sts1  = req_addr == `RXP_ADDR_STS1;
  // The embedded control byte is port specific, so it follows the page too.
  // A host that clears every enable can still read it through its read
  // port, but cannot change it.
  assign embed_wr  = (wr_req && hit_embed) ? cur.wen : 4'h0;

  // One copy per source, so a channel master cannot disturb local paging.
  genvar gs;
  generate
    for (gs = 0; gs < `RXP_NUM_SRC; gs++) begin : g_src
      localparam logic [`RXP_SRC_W-1:0] SRC = `RXP_SRC_W'(gs);
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          page_r[gs] <= page_reset(gs);
        end else if (wr_req && req_src == SRC && hit_sel) begin
          page_r[gs].rd_port <=
            req_wdata[`RXP_RDPORT_MSB:`RXP_RDPORT_LSB];
          page_r[gs].wen <= req_wdata[`RXP_WEN_MSB:`RXP_WEN_LSB];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////

  // Read mux; unmapped and non-paged addresses outside this bank read zero.
  always_comb begin
    rd_nxt = 8'h00;
    if (hit_sel) begin
      rd_nxt = sel_byte(req_src, cur);
    end else if (hit_embed) begin
      rd_nxt = embed_ctl[cur.rd_port];
    end else if (hit_paged) begin
      rd_nxt = pg_rdata_all[8*cur.rd_port +: 8];
      if (hit_sts1) begin
        rd_nxt[`RXP_STS1_PORT_MSB:`RXP_STS1_PORT_LSB] = cur.rd_port;
      end
    end
  end

  // Every request completes, even a write that no port accepts.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
    end
  end

  // Read data holds between reads so a slow host may take it late.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_rdata <= 8'h00;
    end else if (rd_req) begin
      rsp_rdata <= rd_nxt;
    end
  end

  // Broadcast write toward the external per-port blocks.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pg_wr_mask <= 4'h0;
    end else begin
      pg_wr_mask <= (wr_req && hit_paged)
                    ? cur.wen : 4'h0;
    end
  end

  // Address and data stay after the strobe; only the mask marks a write.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pg_waddr <= 8'h00;
      pg_wdata <= 8'h00;
    end else if (wr_req) begin
      pg_waddr <= req_addr;
      pg_wdata <= req_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  genvar gp;
  generate
    for (gp = 0; gp < `RXP_NUM_PORTS; gp++) begin : g_port
      rxp_embed_if eif ();
      assign eif.wr      = embed_wr[gp];
      assign eif.wdata   = req_wdata;
      assign embed_ctl[gp] = eif.ctl;
      rxp_embed_unit u_embed (
        .mclk        (mclk),
        .rst         (rst),
        .rif         (eif),
        .frame_start (frame_start[gp]),
        .pkt_start   (pkt_start[gp]),
        .csi_mode    (csi_mode[gp]),
        .raw_dtype   (raw_dtype[6*gp +: 6]),
        .pkt_dtype   (pkt_dtype[6*gp +: 6])
      );
    end
  endgenerate

endmodule

// [verilog/rxp_page_cfg.svh]
/*
 * Offsets, field positions, reset values and source layout of the receive
 * port paging bank. Assumes it is included once by bare name.
 */
`ifndef RXP_PAGE_CFG_SVH
`define RXP_PAGE_CFG_SVH

`define RXP_ADDR_EMBED_CTL   8'h4B
`define RXP_ADDR_PAGE_SEL    8'h4C
`define RXP_ADDR_STS1        8'h4D
`define RXP_PAGED_LO_A       8'h4D
`define RXP_PAGED_HI_A       8'h7F
`define RXP_PAGED_LO_B       8'hD0
`define RXP_PAGED_HI_B       8'hDF

`define RXP_EMBED_EN_MSB     7
`define RXP_EMBED_EN_LSB     6
`define RXP_EMBED_ID_MSB     5
`define RXP_EMBED_ID_LSB     0
`define RXP_EMBED_CTL_RST    8'h12

`define RXP_PHYS_MSB         7
`define RXP_PHYS_LSB         6
`define RXP_RDPORT_MSB       5
`define RXP_RDPORT_LSB       4
`define RXP_WEN_MSB          3
`define RXP_WEN_LSB          0
`define RXP_STS1_PORT_MSB    7
`define RXP_STS1_PORT_LSB    6

`define RXP_NUM_PORTS        4
`define RXP_NUM_LOCAL        2
`define RXP_NUM_SRC          6
`define RXP_SRC_W            3

`endif

// [verilog/rxp_page_pkg.sv]
/*
 * Types shared by the receive port paging bank. Assumes rxp_page_cfg.svh
 * is on the include path.
 */
package rxp_page_pkg;
  typedef logic [7:0] rxp_byte_type;
  typedef logic [1:0] rxp_port_type;
  typedef logic [5:0] rxp_dtype_type;

  // Page control kept for one access source.
  typedef struct packed {
    rxp_port_type rd_port;
    logic [3:0]   wen;
  } rxp_page_type;
endpackage

// [verilog/rxp_embed_if.sv]
/*
 * Carries register writes and the stored control byte between the paging
 * bank and one per-port embedded type unit. Assumes one clock domain.
 */
`timescale 1ns/1ps
interface rxp_embed_if;
  import rxp_page_pkg::*;
  logic         wr;
  rxp_byte_type wdata;
  rxp_byte_type ctl;

  modport bank (output wr, output wdata, input ctl);
  modport unit (input wr, input wdata, output ctl);
endinterface

// [verilog/rxp_embed_unit.sv]
/*
 * Per-port embedded type control byte and the data type substitution for
 * the first long packets of each frame. Assumes packet strobes come from
 * logic on mclk.
 */
`timescale 1ns/1ps
`include "rxp_page_cfg.svh"
module rxp_embed_unit
  import rxp_page_pkg::*;
(
  input  wire logic    mclk,
  input  wire logic    rst,
  rxp_embed_if.unit    rif,
  input  wire logic    frame_start,
  input  wire logic    pkt_start,
  input  wire logic    csi_mode,
  input  rxp_dtype_type raw_dtype,
  output rxp_dtype_type pkt_dtype
);
  rxp_byte_type  ctl_r;
  logic [1:0]    cnt_r;
  rxp_dtype_type dtype_r;
  logic [1:0]    line_sel;
  logic          use_embed;

  assign rif.ctl   = ctl_r;
  assign pkt_dtype = dtype_r;
  assign line_sel  = ctl_r[`RXP_EMBED_EN_MSB:`RXP_EMBED_EN_LSB];
  // Packet-formatted input keeps its own data types.
  assign use_embed = (line_sel != 2'h0) && !csi_mode
                     && (cnt_r < line_sel);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_r <= `RXP_EMBED_CTL_RST;
    end else if (rif.wr) begin
      ctl_r <= rif.wdata;
    end
  end

  // Counter saturates at three, the largest line count selectable.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= 2'h0;
    end else if (frame_start) begin
      cnt_r <= 2'h0;
    end else if (pkt_start && cnt_r != 2'h3) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dtype_r <= 6'h00;
    end else if (pkt_start) begin
      dtype_r <= use_embed
                 ? ctl_r[`RXP_EMBED_ID_MSB:`RXP_EMBED_ID_LSB]
                 : raw_dtype;
    end
  end
endmodule

// [dv/rxp_page_bank_properties.sv]
/* Port assertions for the paging bank.
   Assumes one clock domain and a bind onto rxp_page_bank. */
`timescale 1ns/1ps
module rxp_page_bank_props
  import rxp_page_pkg::*;
#(
  parameter int NUM_LOCAL = 2
)
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire logic [2:0]  req_src,
  input wire logic        req_write,
  input rxp_byte_type     req_addr,
  input wire logic        rsp_valid,
  input rxp_byte_type     rsp_rdata,
  input wire logic [31:0] pg_rdata_all,
  input wire logic [3:0]  pg_wr_mask,
  input rxp_byte_type     pg_waddr,
  input wire logic [3:0]  pkt_start,
  input wire logic [23:0] pkt_dtype
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic pgd;
  // The embedded type byte is steered per port like the listed ranges.
  assign pgd = req_addr inside {8'h4B, [8'h4D:8'h7F], [8'hD0:8'hDF]};
  //////////////////////////////////////////////////////////////
  AST_RSP: assert property (req_valid |=> rsp_valid)
    else $error("missing response");
  AST_IDLE: assert property (!req_valid |=> !rsp_valid)
    else $error("stray response");
  AST_UNPAGED: assert property (
    req_valid && req_write && !pgd |=> pg_wr_mask == 4'h0)
    else $error("unpaged write reached a port");
  AST_RDMASK: assert property (
    req_valid && !req_write |=> pg_wr_mask == 4'h0)
    else $error("read caused a port write");
  AST_WADDR: assert property (
    req_valid && req_write && pgd
    |=> pg_wr_mask == 4'h0 || pg_waddr == $past(req_addr))
    else $error("port write address wrong");
  AST_PHYS: assert property (
    req_valid && !req_write && req_addr == 8'h4C
    |=> rsp_rdata[7:6] == (($past(req_src) < NUM_LOCAL) ? 2'h0
        : 2'($past(req_src) - NUM_LOCAL)))
    else $error("origin field wrong");
  AST_STS1: assert property (
    req_valid && !req_write && req_addr == 8'h4D
    |=> rsp_rdata[5:0] == 6'($past(pg_rdata_all) >> {rsp_rdata[7:6], 3'h0}))
    else $error("status byte not from read port");
  AST_HOLD: assert property (
    pkt_start == 4'h0 |=> $stable(pkt_dtype))
    else $error("type changed without packet");
endmodule

// [dv/rxp_port_blocks.sv]
/* Per-port register blocks outside the bank: one byte store per port.
   Assumes reads answer combinationally and writes land on mclk. */
`timescale 1ns/1ps
module rxp_port_blocks
  import rxp_page_pkg::*;
(
  input wire logic        mclk,
  input rxp_byte_type     pg_raddr,
  output logic [31:0]     pg_rdata_all,
  input wire logic [3:0]  pg_wr_mask,
  input rxp_byte_type     pg_waddr,
  input rxp_byte_type     pg_wdata
);
  rxp_byte_type mem [4][256];
  // Each port holds a different pattern so a wrong page shows at once.
  initial begin
    foreach (mem[p, a]) mem[p][a] = 8'(p * 64 ^ a);
  end
  always @(posedge mclk) begin
    for (int p = 0; p < 4; p++) begin
      if (pg_wr_mask[p]) mem[p][pg_waddr] <= pg_wdata;
    end
  end
  always_comb begin
    for (int p = 0; p < 4; p++) pg_rdata_all[8*p +: 8] = mem[p][pg_raddr];
  end
endmodule

// [dv/rxp_page_bank_tb_top.sv]
/* Self-checking bench for the paging bank.
   Assumes the port block model stands behind the paged ports. */
`timescale 1ns/1ps
module rxp_page_bank_tb_top import rxp_page_pkg::*;;
  logic         mclk, rst, req_valid, req_write, rsp_valid;
  logic [2:0]   req_src;
  rxp_byte_type req_addr, req_wdata, rsp_rdata, pg_raddr, pg_waddr, pg_wdata;
  logic [31:0]  pg_rdata_all;
  logic [3:0]   pg_wr_mask, frame_start, pkt_start, csi_mode;
  logic [23:0]  raw_dtype, pkt_dtype;
  int           num_errors = 0;
  int           checks = 0;
  typedef struct packed {
    logic [2:0]   src;
    rxp_byte_type addr;
    rxp_byte_type exp;
  } rxp_row_type;
  rxp_row_type  rows [11] = '{'{3'h0, 8'h4C, 8'h00}, '{3'h1, 8'h4C, 8'h00},
    '{3'h2, 8'h4C, 8'h01}, '{3'h3, 8'h4C, 8'h52}, '{3'h4, 8'h4C, 8'hA4},
    '{3'h5, 8'h4C, 8'hF8}, '{3'h0, 8'h4B, 8'h12}, '{3'h0, 8'h49, 8'h00},
    '{3'h3, 8'h60, 8'h20}, '{3'h5, 8'h4D, 8'hCD}, '{3'h4, 8'hD0, 8'h50}};
  rxp_byte_type bnd [5] = '{8'h49, 8'h7F, 8'h80, 8'hDF, 8'hE0};
  logic [3:0]   bmk [5] = '{4'h0, 4'h1, 4'h0, 4'h1, 4'h0};
  rxp_page_bank #(.NUM_LOCAL(2)) uut (.mclk, .rst, .req_valid, .req_src,
    .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .pg_raddr,
    .pg_rdata_all, .pg_wr_mask, .pg_waddr, .pg_wdata, .frame_start,
    .pkt_start, .csi_mode, .raw_dtype, .pkt_dtype);
  rxp_port_blocks blk (.mclk, .pg_raddr, .pg_rdata_all, .pg_wr_mask,
    .pg_waddr, .pg_wdata);
  //////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [2:0] s, input logic w,
                     input rxp_byte_type a, input rxp_byte_type d);
    @(negedge mclk);
    req_valid = 1'b1;
    req_src = s;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge mclk);
    req_valid = 1'b0;
  endtask
  task automatic pls(input logic [3:0] f, input logic [3:0] s);
    @(negedge mclk);
    frame_start = f;
    pkt_start = s;
    @(negedge mclk);
    frame_start = 4'h0;
    pkt_start = 4'h0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_src = 3'h0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_wdata = 8'h00;
    frame_start = 4'h0;
    pkt_start = 4'h0;
    csi_mode = 4'h0;
    raw_dtype = {4{6'h2C}};
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    foreach (rows[i]) begin
      acc(rows[i].src, 1'b0, rows[i].addr, 8'h00);
      chk(rsp_rdata, rows[i].exp);
    end
    $display("table done");
    acc(3'h0, 1'b1, 8'h4C, 8'h05);
    acc(3'h0, 1'b1, 8'h60, 8'hA5);
    chk(pg_wr_mask, 4'h5);
    for (int p = 0; p < 4; p++) begin
      acc(3'h0, 1'b1, 8'h4C, 8'(p * 16 + 5));
      acc(3'h0, 1'b0, 8'h60, 8'h00);
      chk(rsp_rdata, p[0] ? 8'(p * 64 ^ 8'h60) : 8'hA5);
    end
    acc(3'h1, 1'b0, 8'h4C, 8'h00);
    chk(rsp_rdata, 8'h00);
    acc(3'h1, 1'b1, 8'h60, 8'h11);
    chk({rsp_valid, pg_wr_mask}, 5'h10);
    foreach (bnd[i]) begin
      acc(3'h2, 1'b1, bnd[i], 8'h3C);
      chk(pg_wr_mask, bmk[i]);
    end
    $display("paging done");
    for (int n = 0; n < 4; n++) begin
      acc(3'h2, 1'b1, 8'h4B, 8'(n * 64 + 8'h2A));
      pls(4'h1, 4'h0);
      for (int k = 0; k < 4; k++) begin
        pls(4'h0, 4'h1);
        chk(pkt_dtype[5:0], k < n ? 6'h2A : 6'h2C);
      end
    end
    acc(3'h2, 1'b0, 8'h4B, 8'h00);
    chk(rsp_rdata, 8'hEA);
    acc(3'h5, 1'b0, 8'h4B, 8'h00);
    chk(rsp_rdata, 8'h12);
    csi_mode = 4'h1;
    pls(4'h1, 4'h0);
    pls(4'h0, 4'h1);
    chk(pkt_dtype[5:0], 6'h2C);
    csi_mode = 4'h0;
    $display("embedded done");
    rst = 1'b1;
    @(negedge mclk);
    chk(pkt_dtype, 24'h0);
    rst = 1'b0;
    acc(3'h0, 1'b0, 8'h4C, 8'h00);
    chk(rsp_rdata, 8'h00);
    acc(3'h2, 1'b0, 8'h4B, 8'h00);
    chk(rsp_rdata, 8'h12);
    $display("reset done");
    close_out();
  end
endmodule
bind rxp_page_bank rxp_page_bank_props #(.NUM_LOCAL(NUM_LOCAL)) u_props (
  .mclk, .rst, .req_valid, .req_src, .req_write, .req_addr, .rsp_valid,
  .rsp_rdata, .pg_rdata_all, .pg_wr_mask, .pg_waddr, .pkt_start, .pkt_dtype);
